/* design/oscc_pkg.sv */
/*
 * Package for the oscillator settle, interrupt and clock-output control block.
 * Assumes a 16-bit register view placed on a 32-bit classic Wishbone word bus.
 */
package oscc_pkg;

	// ****************************************
	// register byte addresses (word aligned)
	// ****************************************
	localparam logic [3:0] ADDR_HS_OSC_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_SETTLE_FLAGS = 4'h4;
	localparam logic [3:0] ADDR_SETTLE_IRQ_EN = 4'h8;
	localparam logic [3:0] ADDR_CLKOUT_CTRL = 4'hC;

	// ****************************************
	// field positions
	// ****************************************
	localparam int TYPE_SEL_LSB = 8;
	localparam int DRIVE_GAIN_LSB = 4;
	localparam int SETTLE_SEL_LSB = 0;
	localparam int HS_FLAG_BIT = 2;
	localparam int INT_FLAG_BIT = 0;
	localparam int CLKOUT_DIV_LSB = 4;
	localparam int CLKOUT_SRC_LSB = 2;
	localparam int CLKOUT_EN_BIT = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [1:0] TYPE_SEL_RST = 2'h0;
	localparam logic [1:0] DRIVE_GAIN_RST = 2'h3;
	localparam logic [2:0] SETTLE_SEL_RST = 3'h6;
	localparam logic [2:0] CLKOUT_DIV_RST = 3'h0;
	localparam logic [1:0] CLKOUT_SRC_RST = 2'h0;

	// ****************************************
	// encodings and timing
	// ****************************************
	localparam logic [1:0] TYPE_INTERNAL = 2'h0;
	localparam logic [1:0] TYPE_CRYSTAL = 2'h2;
	localparam logic [1:0] SRC_INT_OSC = 2'h0;
	localparam logic [1:0] SRC_HS_OSC = 2'h2;
	localparam logic [1:0] SRC_SYSTEM = 2'h3;
	localparam int SETTLE_MIN_CLOCKS = 4;
	localparam int SETTLE_MAX_CLOCKS = 65536;

	typedef enum logic [1:0] {OSCC_IDLE, OSCC_WAIT, OSCC_DONE} oscc_settle_e;

endpackage

/* design/oscc_top.sv */
/*
 * Oscillator settle timing, settle interrupt flags and divided clock output.
 * Assumes oscillator clocks arrive as pins (synchronised here) and that the
 * sleep/halt indication comes from logic on ref_clk.
 */
module oscc_top
#(
	parameter int SETTLE_MAX = oscc_pkg::SETTLE_MAX_CLOCKS
)
(
	// system
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clkEn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// oscillators
	input wire logic hsOscStart,
	input wire logic intOscStart,
	input wire logic hsOscClk,
	input wire logic intOscClk,
	input wire logic sleepHalt,
	output logic [1:0] hsOscTypeSel,
	output logic [1:0] hsOscDriveGain,
	// interrupt and clock output
	output logic irq,
	output logic clockOutputPin
);
	import oscc_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [16:0] settleCount(input logic [2:0] code);
		settleCount = 17'(SETTLE_MIN_CLOCKS) << (2 * code);
		if (settleCount > 17'(SETTLE_MAX))
			settleCount = 17'(SETTLE_MAX);
	endfunction

	function automatic logic rising(input logic now, input logic prev);
		rising = now & ~prev;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] hsSync_q, intSync_q, hsStartSync_q, intStartSync_q;
	logic hsSeen_q, intSeen_q, hsStartSeen_q, intStartSeen_q;
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			hsSync_q <= 2'h0;
			intSync_q <= 2'h0;
			hsStartSync_q <= 2'h0;
			intStartSync_q <= 2'h0;
			hsSeen_q <= 1'b0;
			intSeen_q <= 1'b0;
			hsStartSeen_q <= 1'b0;
			intStartSeen_q <= 1'b0;
		end
		else if (clkEn)
		begin
			hsSync_q <= {hsSync_q[0], hsOscClk};
			intSync_q <= {intSync_q[0], intOscClk};
			hsStartSync_q <= {hsStartSync_q[0], hsOscStart};
			intStartSync_q <= {intStartSync_q[0], intOscStart};
			hsSeen_q <= hsSync_q[1];
			intSeen_q <= intSync_q[1];
			hsStartSeen_q <= hsStartSync_q[1];
			intStartSeen_q <= intStartSync_q[1];
		end
	end
	logic hsTick, intTick, hsStartPulse, intStartPulse;
	assign hsTick = rising(hsSync_q[1], hsSeen_q);
	assign intTick = rising(intSync_q[1], intSeen_q);
	assign hsStartPulse = rising(hsStartSync_q[1], hsStartSeen_q);
	assign intStartPulse = rising(intStartSync_q[1], intStartSeen_q);

	// ****************************************
	// registers
	// ****************************************
	logic [1:0] typeSel_q, gain_q, clkoutSrc_q;
	logic [2:0] settleSel_q, clkoutDiv_q;
	logic clkoutEn_q, hsFlag_q, intFlag_q, hsIrqEn_q, intIrqEn_q, irq_d;
	logic access, wrLo, wrHi, clrFlags, hsDone, intDone, srcTick, srcLevel, outNext;
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrLo = access & wb_we_i & wb_sel_i[0];
	assign wrHi = access & wb_we_i & wb_sel_i[1];

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			typeSel_q <= TYPE_SEL_RST;
			gain_q <= DRIVE_GAIN_RST;
			settleSel_q <= SETTLE_SEL_RST;
		end
		else if (clkEn && wb_adr_i == ADDR_HS_OSC_CONFIG)
		begin
			// reserved codes are refused, the field keeps its value
			if (wrHi && (wb_dat_i[9:8] == TYPE_INTERNAL || wb_dat_i[9:8] == TYPE_CRYSTAL))
				typeSel_q <= wb_dat_i[9:8];
			if (wrLo)
			begin
				gain_q <= wb_dat_i[5:4];
				settleSel_q <= wb_dat_i[2:0];
			end
		end
	end
	assign hsOscTypeSel = typeSel_q;
	assign hsOscDriveGain = gain_q;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			hsIrqEn_q <= 1'b0;
			intIrqEn_q <= 1'b0;
		end
		else if (clkEn && wrLo && wb_adr_i == ADDR_SETTLE_IRQ_EN)
		begin
			hsIrqEn_q <= wb_dat_i[HS_FLAG_BIT];
			intIrqEn_q <= wb_dat_i[INT_FLAG_BIT];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			clkoutDiv_q <= CLKOUT_DIV_RST;
			clkoutSrc_q <= CLKOUT_SRC_RST;
			clkoutEn_q <= 1'b0;
		end
		else if (clkEn && wrLo && wb_adr_i == ADDR_CLKOUT_CTRL)
		begin
			if (wb_dat_i[3:2] != 2'h1)
				clkoutSrc_q <= wb_dat_i[3:2];
			// system clock source forces divide-by-one
			clkoutDiv_q <= (wb_dat_i[3:2] == SRC_SYSTEM) ? 3'h0 : wb_dat_i[6:4];
			clkoutEn_q <= wb_dat_i[CLKOUT_EN_BIT];
		end
	end

	// ****************************************
	// settle counters
	// ****************************************
	oscc_settle_e hsState_q, intState_q;
	logic [16:0] hsCnt_q, intCnt_q;
	assign hsDone = hsState_q == OSCC_WAIT && hsTick && hsCnt_q == 17'h00001;
	assign intDone = intState_q == OSCC_WAIT && intTick && intCnt_q == 17'h00001;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			hsState_q <= OSCC_IDLE;
			hsCnt_q <= 17'h00000;
		end
		else if (clkEn)
		begin
			case (hsState_q)
				OSCC_IDLE, OSCC_DONE:
					if (hsStartPulse)
					begin
						hsState_q <= OSCC_WAIT;
						hsCnt_q <= settleCount(settleSel_q);
					end
				OSCC_WAIT:
					if (hsTick)
					begin
						hsCnt_q <= hsCnt_q - 17'h00001;
						if (hsCnt_q == 17'h00001)
							hsState_q <= OSCC_DONE;
					end
				default:
					hsState_q <= OSCC_IDLE;
			endcase
		end
	end

	// internal oscillator wait uses the same code table
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			intState_q <= OSCC_IDLE;
			intCnt_q <= 17'h00000;
		end
		else if (clkEn)
		begin
			case (intState_q)
				OSCC_IDLE, OSCC_DONE:
					if (intStartPulse)
					begin
						intState_q <= OSCC_WAIT;
						intCnt_q <= settleCount(settleSel_q);
					end
				OSCC_WAIT:
					if (intTick)
					begin
						intCnt_q <= intCnt_q - 17'h00001;
						if (intCnt_q == 17'h00001)
							intState_q <= OSCC_DONE;
					end
				default:
					intState_q <= OSCC_IDLE;
			endcase
		end
	end

	// ****************************************
	// flags and interrupt
	// ****************************************
	assign clrFlags = wrLo && wb_adr_i == ADDR_SETTLE_FLAGS;
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			hsFlag_q <= 1'b0;
			intFlag_q <= 1'b0;
		end
		else if (clkEn)
		begin
			// a set in the clear cycle wins
			if (hsDone)
				hsFlag_q <= 1'b1;
			else if (clrFlags && wb_dat_i[HS_FLAG_BIT])
				hsFlag_q <= 1'b0;
			if (intDone)
				intFlag_q <= 1'b1;
			else if (clrFlags && wb_dat_i[INT_FLAG_BIT])
				intFlag_q <= 1'b0;
		end
	end

	assign irq_d = (hsFlag_q & hsIrqEn_q) | (intFlag_q & intIrqEn_q);
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			irq <= 1'b0;
		else if (clkEn)
			irq <= irq_d;
	end

	// ****************************************
	// bus answer
	// ****************************************
	logic [15:0] rd_d;
	always_comb
	begin
		rd_d = 16'h0000;
		case (wb_adr_i)
			ADDR_HS_OSC_CONFIG:
				rd_d = {6'h00, typeSel_q, 2'h0, gain_q, 1'b0, settleSel_q};
			ADDR_SETTLE_FLAGS:
				rd_d = {13'h0000, hsFlag_q, 1'b0, intFlag_q};
			ADDR_SETTLE_IRQ_EN:
				rd_d = {13'h0000, hsIrqEn_q, 1'b0, intIrqEn_q};
			ADDR_CLKOUT_CTRL:
				rd_d = {9'h000, clkoutDiv_q, clkoutSrc_q, 1'b0, clkoutEn_q};
			default:
				rd_d = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else if (clkEn)
		begin
			wb_ack_o <= access;
			wb_dat_o <= access ? {16'h0000, rd_d} : 32'h00000000;
		end
	end

	// ****************************************
	// clock output
	// ****************************************
	// sampled clocks can only be followed up to a quarter of ref_clk;
	// divided clocks toggle on sampled edges, so enable changes may clip a pulse
	logic [6:0] divCnt_q;
	always_comb
	begin
		srcTick = 1'b0;
		srcLevel = 1'b0;
		case (clkoutSrc_q)
			SRC_INT_OSC:
			begin
				srcTick = intTick;
				srcLevel = intSync_q[1];
			end
			SRC_HS_OSC:
			begin
				srcTick = hsTick;
				srcLevel = hsSync_q[1];
			end
			default:
			begin
				srcTick = 1'b0;
				srcLevel = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		if (clkoutSrc_q == SRC_SYSTEM)
			outNext = ~clockOutputPin; // system clock shown as ref_clk divided by two
		else if (clkoutDiv_q == 3'h0)
			outNext = srcLevel;
		else
			outNext = divCnt_q[clkoutDiv_q - 3'h1];
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			divCnt_q <= 7'h00;
			clockOutputPin <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!clkoutEn_q)
			begin
				divCnt_q <= 7'h00;
				clockOutputPin <= 1'b0;
			end
			else if (clkoutSrc_q == SRC_SYSTEM && sleepHalt)
				clockOutputPin <= clockOutputPin;
			else
			begin
				if (srcTick)
					divCnt_q <= divCnt_q + 7'h01;
				clockOutputPin <= outNext;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_flag_clear: assert property (@(posedge ref_clk) disable iff (srst)
		clkEn && clrFlags && wb_dat_i[HS_FLAG_BIT] && !hsDone |=> !hsFlag_q)
		else $error("settle flag not cleared by write of one");
	a_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
		clkEn && hsDone |=> hsFlag_q)
		else $error("settle flag not set at end of wait");
	a_irq_gate: assert property (@(posedge ref_clk) disable iff (srst)
		clkEn && !(hsFlag_q && hsIrqEn_q) && !(intFlag_q && intIrqEn_q) |=> !irq)
		else $error("interrupt without enabled flag");
	a_out_disabled: assert property (@(posedge ref_clk) disable iff (srst)
		clkEn && !clkoutEn_q |=> !clockOutputPin && divCnt_q == 7'h00)
		else $error("clock output active while disabled");
	a_sys_div_one: assert property (@(posedge ref_clk) disable iff (srst)
		clkoutSrc_q == SRC_SYSTEM |-> clkoutDiv_q == 3'h0)
		else $error("divider not one for system source");
	a_sleep_hold: assert property (@(posedge ref_clk) disable iff (srst)
		clkEn && clkoutEn_q && clkoutSrc_q == SRC_SYSTEM && sleepHalt |=> $stable(clockOutputPin))
		else $error("output toggled in sleep");
	a_type_legal: assert property (@(posedge ref_clk) disable iff (srst)
		typeSel_q == TYPE_INTERNAL || typeSel_q == TYPE_CRYSTAL)
		else $error("reserved oscillator type held");
	a_int_reset: assert property (@(posedge ref_clk)
		$fell(srst) |-> !intFlag_q)
		else $error("internal flag set after reset");
	a_ack_pulse: assert property (@(posedge ref_clk) disable iff (srst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule

/* sim/test_oscc_top.sv */
/*
 * Self-checking bench for the oscillator settle, interrupt and clock-output block.
 * Assumes oscc_pkg and oscc_top are compiled first; the bench plays bus master and oscillators.
 */
module test_oscc_top;
	timeunit 1ns;
	timeprecision 100ps;
	import oscc_pkg::*;

	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic clkEn = 1'b1;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [3:0] wbAdr = 4'h0;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatIn = 32'h0;
	logic [31:0] wbDatOut;
	logic wbAck;
	logic hsStart = 1'b0;
	logic intStart = 1'b0;
	logic hsClk = 1'b0;
	logic intClk = 1'b0;
	logic sleepHalt = 1'b0;
	logic [1:0] typeSel;
	logic [1:0] driveGain;
	logic irq;
	logic pinOut;
	logic pinPrev = 1'b0;
	int riseCnt = 0;
	int base;
	int fails = 0;
	int n_checks = 0;
	logic [15:0] rd;

	// short settle cap keeps the long wait codes cheap to run
	oscc_top #(.SETTLE_MAX(16)) u_oscc_top (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatIn), .wb_dat_o(wbDatOut), .wb_ack_o(wbAck),
		.hsOscStart(hsStart), .intOscStart(intStart), .hsOscClk(hsClk), .intOscClk(intClk),
		.sleepHalt(sleepHalt), .hsOscTypeSel(typeSel), .hsOscDriveGain(driveGain),
		.irq(irq), .clockOutputPin(pinOut));

	always #12.5 ref_clk = ~ref_clk;

	// counts rising edges of the output pin
	always @(posedge ref_clk)
	begin
		pinPrev <= pinOut;
		if (pinOut === 1'b1 && pinPrev === 1'b0)
			riseCnt <= riseCnt + 1;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [15:0] dat);
		int i;
		@(posedge ref_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'h3;
		wbDatIn <= {16'h0000, dat};
		for (i = 0; i < 50; i++)
		begin
			@(posedge ref_clk);
			if (wbAck === 1'b1)
				break;
		end
		if (i == 50)
		begin
			check(32'h0, 32'h1, "bus answer timeout");
			end_of_test();
		end
		rd = wbDatOut[15:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] adr, input logic [15:0] dat);
		wbXfer(1'b1, adr, dat);
	endtask

	task automatic rdChk(input logic [3:0] adr, input logic [15:0] exp, input string what);
		wbXfer(1'b0, adr, 16'h0000);
		check(rd, exp, what);
	endtask

	// oscillator period of 8 system clocks, well under the quarter-rate limit
	task automatic oscPulses(input bit hs, input int n);
		repeat (n)
		begin
			@(posedge ref_clk);
			hsClk <= hs;
			intClk <= !hs;
			repeat (4) @(posedge ref_clk);
			hsClk <= 1'b0;
			intClk <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask

	task automatic settleRun(input bit hs, input int edges, input int bitNo);
		@(posedge ref_clk);
		hsStart <= hs;
		intStart <= !hs;
		repeat (8) @(posedge ref_clk);
		oscPulses(hs, edges - 1);
		repeat (4) @(posedge ref_clk);
		rdChk(ADDR_SETTLE_FLAGS, 16'h0000, "flag before last edge");
		oscPulses(hs, 1);
		for (int i = 0; i < 20; i++)
		begin
			wbXfer(1'b0, ADDR_SETTLE_FLAGS, 16'h0000);
			if (rd[bitNo] === 1'b1)
				break;
		end
		check(rd, 16'h0001 << bitNo, "settle flag after wait");
		if (rd[bitNo] !== 1'b1)
			end_of_test();
		hsStart <= 1'b0;
		intStart <= 1'b0;
	endtask

	function automatic logic near(input int got, input int exp);
		return got >= exp - 1 && got <= exp + 1;
	endfunction

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		check(driveGain, 2'h3, "gain out at reset");
		check({irq, pinOut}, 2'b00, "irq and pin at reset");
		rdChk(ADDR_HS_OSC_CONFIG, 16'h0036, "config reset");
		rdChk(ADDR_SETTLE_FLAGS, 16'h0000, "flags reset");
		rdChk(ADDR_SETTLE_IRQ_EN, 16'h0000, "enables reset");
		rdChk(ADDR_CLKOUT_CTRL, 16'h0000, "clkout reset");
		wr(ADDR_HS_OSC_CONFIG, 16'hFFFF);
		rdChk(ADDR_HS_OSC_CONFIG, 16'h0037, "reserved bits and type 3");
		wr(ADDR_HS_OSC_CONFIG, 16'h0210);
		rdChk(ADDR_HS_OSC_CONFIG, 16'h0210, "crystal, low gain");
		check({typeSel, driveGain}, {TYPE_CRYSTAL, 2'h1}, "config outputs");
		wr(ADDR_HS_OSC_CONFIG, 16'h0100);
		rdChk(ADDR_HS_OSC_CONFIG, 16'h0200, "type 1 ignored");
		check(typeSel, TYPE_CRYSTAL, "type out kept");
		rdChk(4'h2, 16'h0000, "unmapped read");
		settleRun(1'b0, SETTLE_MIN_CLOCKS, INT_FLAG_BIT);
		check(irq, 1'b0, "flag without enable");
		wr(ADDR_SETTLE_IRQ_EN, 16'hFFFC);
		rdChk(ADDR_SETTLE_IRQ_EN, 16'h0004, "enable layout");
		check(irq, 1'b0, "other enable only");
		wr(ADDR_SETTLE_IRQ_EN, 16'h0005);
		@(posedge ref_clk);
		check(irq, 1'b1, "enabled flag raises irq");
		wr(ADDR_SETTLE_FLAGS, 16'h0000);
		rdChk(ADDR_SETTLE_FLAGS, 16'h0001, "zero write ignored");
		wr(ADDR_SETTLE_FLAGS, 16'h0001);
		rdChk(ADDR_SETTLE_FLAGS, 16'h0000, "one write clears");
		check(irq, 1'b0, "irq drops after clear");
		wr(ADDR_HS_OSC_CONFIG, 16'h0201);
		settleRun(1'b1, 16, HS_FLAG_BIT);
		check(irq, 1'b1, "hs flag irq");
		wr(ADDR_SETTLE_IRQ_EN, 16'h0001);
		@(posedge ref_clk);
		check(irq, 1'b0, "masked hs flag");
		wr(ADDR_SETTLE_FLAGS, 16'hFFFF);
		rdChk(ADDR_SETTLE_FLAGS, 16'h0000, "both cleared");
		for (int d = 0; d < 8; d++)
		begin
			wr(ADDR_CLKOUT_CTRL, {9'h000, d[2:0], 4'h1});
			rdChk(ADDR_CLKOUT_CTRL, {9'h000, d[2:0], 4'h1}, "divider code");
			base = riseCnt;
			oscPulses(1'b0, 128);
			repeat (4) @(posedge ref_clk);
			check(near(riseCnt - base, 128 >> d), 1'b1, "internal divided rate");
		end
		wr(ADDR_CLKOUT_CTRL, 16'h0019);
		base = riseCnt;
		oscPulses(1'b1, 32);
		check(near(riseCnt - base, 16), 1'b1, "hs source rate");
		wr(ADDR_CLKOUT_CTRL, 16'h0005);
		rdChk(ADDR_CLKOUT_CTRL, 16'h0009, "source 1 ignored");
		wr(ADDR_CLKOUT_CTRL, 16'h005D);
		rdChk(ADDR_CLKOUT_CTRL, 16'h000D, "system source forces 1/1");
		base = riseCnt;
		repeat (20) @(posedge ref_clk);
		check(near(riseCnt - base, 10), 1'b1, "system source rate");
		sleepHalt <= 1'b1;
		repeat (2) @(posedge ref_clk);
		base = riseCnt;
		repeat (20) @(posedge ref_clk);
		check(riseCnt - base, 0, "stopped in sleep");
		sleepHalt <= 1'b0;
		wr(ADDR_CLKOUT_CTRL, 16'h000C);
		repeat (2) @(posedge ref_clk);
		base = riseCnt;
		repeat (20) @(posedge ref_clk);
		check({pinOut, 31'(riseCnt - base)}, 32'h0, "disabled pin low");
		end_of_test();
	end
endmodule
